// [design/sfx_simd_fp_exception_control.sv]
// simd fp exception gating, state save/restore and apb register file
//
// How it works
// - packed integer operations never raise numeric faults
// - six fault classes detected, each with its own mask bit
// - fault conditions follow ieee 754, denormal operand aside
// - masked faults write a default result and raise nothing
// - any unmasked detected class raises the simd fp fault
// - unmasked fault with handler flag clear raises invalid opcode instead
// - numeric error report flag is ignored, treated as always set
// - ignore numeric error input is ignored, unmasked faults always reported
// - simd operation with emulate math flag set raises invalid opcode
// - full save stores data registers and control/status; restore reloads them
// - data registers and control/status are also reachable one by one
// - full save and restore also carry the legacy fp state
// - task switched flag raises device unavailable before touching fp state, except a simd operation with emulate set raises invalid opcode
`timescale 1ns/100ps
module sfx_simd_fp_exception_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ignore_numeric_error_input,
    output logic simd_fp_fault,
    output logic invalid_opcode_fault,
    output logic device_unavailable_fault,
    output logic irq
);

    sfx_pkg::sfx_state_t s;
    sfx_pkg::sfx_state_t next_s;
    sfx_pkg::sfx_cmd_t cmd;
    sfx_pkg::sfx_fp_in_t fp_in;
    sfx_pkg::sfx_fp_out_t fp_out;

    // true when the address falls in the data register window
    function automatic logic is_data(input logic [11:0] a);
        return (a[11:5] == sfx_pkg::OFS_DATA_BASE[11:5]) && (a[1:0] == 2'b00);
    endfunction

    // read decode: {hit, word}
    function automatic logic [32:0] rd_word(input sfx_pkg::sfx_state_t st,
            input logic [11:0] a, input logic ign);
        logic [31:0] v;
        logic hit;
        v = sfx_pkg::RST_WORD;
        hit = 1'b1;
        case (a)
            sfx_pkg::OFS_MCTRL: begin
                v[sfx_pkg::MCTRL_EMU_BIT] = st.emu;
                v[sfx_pkg::MCTRL_TSW_BIT] = st.tsw;
                v[sfx_pkg::MCTRL_NER_BIT] = st.ner;
            end
            sfx_pkg::OFS_XCTRL: begin
                v[sfx_pkg::XCTRL_OSH_BIT] = st.osh;
            end
            sfx_pkg::OFS_CSR: begin
                v[sfx_pkg::CSR_FLAG_LSB +: sfx_pkg::NUM_FAULTS] = st.flags;
                v[sfx_pkg::CSR_MASK_LSB +: sfx_pkg::NUM_FAULTS] = st.masks;
            end
            sfx_pkg::OFS_CMD: begin
                v = sfx_pkg::RST_WORD;
            end
            sfx_pkg::OFS_RESULT: begin
                v[1:0] = st.last_fault;
                v[sfx_pkg::RES_IGN_BIT] = ign;
                v[sfx_pkg::RES_FLAG_LSB +: sfx_pkg::NUM_FAULTS] = st.last_flags;
            end
            sfx_pkg::OFS_IRQ_STATUS: begin
                v[sfx_pkg::NUM_IRQ-1:0] = st.irq_status;
            end
            sfx_pkg::OFS_IRQ_CLEAR: begin
                v = sfx_pkg::RST_WORD;
            end
            sfx_pkg::OFS_IRQ_ENABLE: begin
                v[sfx_pkg::NUM_IRQ-1:0] = st.irq_enable;
            end
            sfx_pkg::OFS_LEGACY: begin
                v = st.legacy;
            end
            default: begin
                hit = is_data(a);
                v = hit ? st.data[a[4:2]] : sfx_pkg::RST_WORD;
            end
        endcase
        return {hit, v};
    endfunction

    // operands for the arithmetic unit are the data registers named by the command word
    always_comb begin
        cmd = sfx_pkg::sfx_cmd_t'(pwdata);
        fp_in.op_div = (cmd.op == sfx_pkg::OP_FDIV);
        fp_in.a = s.data[cmd.srca];
        fp_in.b = s.data[cmd.srcb];
    end

    sfx_fp_arith u_arith (
        .fp_in(fp_in),
        .masks(s.masks),
        .fp_out(fp_out)
    );

    // next state: bus decode, command execution and interrupt bookkeeping
    always_comb begin
        logic wr;
        logic [sfx_pkg::NUM_IRQ-1:0] ev;
        logic [32:0] rd;
        sfx_pkg::sfx_fault_t flt;
        logic touches;
        logic simd_op;
        next_s = s;
        wr = psel & penable & pwrite;
        ev = '0;
        rd = '0;
        flt = sfx_pkg::FLT_NONE;
        touches = 1'b0;
        simd_op = 1'b0;
        next_s.p_simd = 1'b0;
        next_s.p_udef = 1'b0;
        next_s.p_navl = 1'b0;
        // read data is captured in the setup cycle so it comes from a flop
        if (psel && !penable) begin
            rd = rd_word(s, paddr, ignore_numeric_error_input);
            next_s.prdata = rd[31:0];
            next_s.pslverr = ~rd[32];
        end
        if (wr) begin
            case (paddr)
                sfx_pkg::OFS_MCTRL: begin
                    next_s.emu = pwdata[sfx_pkg::MCTRL_EMU_BIT];
                    next_s.tsw = pwdata[sfx_pkg::MCTRL_TSW_BIT];
                    next_s.ner = pwdata[sfx_pkg::MCTRL_NER_BIT];
                end
                sfx_pkg::OFS_XCTRL: begin
                    next_s.osh = pwdata[sfx_pkg::XCTRL_OSH_BIT];
                end
                sfx_pkg::OFS_CSR: begin
                    next_s.flags = pwdata[sfx_pkg::CSR_FLAG_LSB +: sfx_pkg::NUM_FAULTS];
                    next_s.masks = pwdata[sfx_pkg::CSR_MASK_LSB +: sfx_pkg::NUM_FAULTS];
                end
                sfx_pkg::OFS_IRQ_CLEAR: begin
                    next_s.irq_status = s.irq_status & ~pwdata[sfx_pkg::NUM_IRQ-1:0];
                end
                sfx_pkg::OFS_IRQ_ENABLE: begin
                    next_s.irq_enable = pwdata[sfx_pkg::NUM_IRQ-1:0];
                end
                sfx_pkg::OFS_LEGACY: begin
                    next_s.legacy = pwdata;
                end
                sfx_pkg::OFS_CMD: begin
                    touches = (cmd.op != sfx_pkg::OP_NOP);
                end
                default: begin
                    // one data register moved at a time
                    if (is_data(paddr)) begin
                        next_s.data[paddr[4:2]] = pwdata;
                    end
                end
            endcase
        end
        simd_op = touches && (cmd.op != sfx_pkg::OP_FULL_SAVE)
            && (cmd.op != sfx_pkg::OP_FULL_RESTORE);
        if (touches) begin
            ev[sfx_pkg::IRQ_DONE] = 1'b1;
            if (simd_op && s.emu) begin
                // no emulation path, emulate flag wins over task switch
                flt = sfx_pkg::FLT_UDEF;
            end else if (s.tsw) begin
                // trap before any state is touched
                flt = sfx_pkg::FLT_NAVL;
            end else begin
                case (cmd.op)
                    sfx_pkg::OP_FMUL, sfx_pkg::OP_FDIV: begin
                        // sticky flags for all six classes
                        next_s.flags = s.flags | fp_out.flags;
                        next_s.last_flags = fp_out.flags;
                        // ieee class detection in the arithmetic unit
                        if (|(fp_out.flags & ~s.masks)) begin
                            // no declared handler demotes to invalid opcode
                            // pin level plays no part here
                            flt = s.osh ? sfx_pkg::FLT_SIMD : sfx_pkg::FLT_UDEF;
                        end else begin
                            next_s.data[cmd.dst] = fp_out.result;
                        end
                    end
                    sfx_pkg::OP_PIADD: begin
                        // lane adds never report numeric faults
                        for (int i = 0; i < 4; i++) begin
                            next_s.data[cmd.dst][8*i +: 8] =
                                fp_in.a[8*i +: 8] + fp_in.b[8*i +: 8];
                        end
                        next_s.last_flags = '0;
                    end
                    sfx_pkg::OP_MOVE: begin
                        next_s.data[cmd.dst] = fp_in.a;
                    end
                    sfx_pkg::OP_FULL_SAVE: begin
                        // data and control/status into the image
                        next_s.img_data = s.data;
                        next_s.img_flags = s.flags;
                        next_s.img_masks = s.masks;
                        next_s.img_legacy = s.legacy;
                    end
                    sfx_pkg::OP_FULL_RESTORE: begin
                        next_s.data = s.img_data;
                        next_s.flags = s.img_flags;
                        next_s.masks = s.img_masks;
                        next_s.legacy = s.img_legacy;
                    end
                    default: begin
                        next_s.last_flags = s.last_flags;
                    end
                endcase
            end
            next_s.last_fault = flt;
            next_s.p_simd = (flt == sfx_pkg::FLT_SIMD);
            next_s.p_udef = (flt == sfx_pkg::FLT_UDEF);
            next_s.p_navl = (flt == sfx_pkg::FLT_NAVL);
            ev[sfx_pkg::IRQ_SIMD] = (flt == sfx_pkg::FLT_SIMD);
            ev[sfx_pkg::IRQ_UDEF] = (flt == sfx_pkg::FLT_UDEF);
            ev[sfx_pkg::IRQ_NAVL] = (flt == sfx_pkg::FLT_NAVL);
        end
        // a new event wins over a clear in the same cycle
        next_s.irq_status = next_s.irq_status | ev;
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.masks <= sfx_pkg::RST_MASKS;
            s.last_fault <= sfx_pkg::FLT_NONE;
        end else begin
            s <= next_s;
        end
    end

    // outputs
    assign prdata = s.prdata;
    assign pready = 1'b1;
    assign pslverr = s.pslverr & psel & penable;
    assign simd_fp_fault = s.p_simd;
    assign invalid_opcode_fault = s.p_udef;
    assign device_unavailable_fault = s.p_navl;

    // interrupt level from enabled sticky status bits
    sfx_unused_guard u_irq (
        .irq_status(s.irq_status),
        .irq_enable(s.irq_enable),
        .irq(irq)
    );

endmodule

// [design/sfx_pkg.sv]
// shared constants, types and register map for the simd fp exception control block
package sfx_pkg;

    // register byte offsets
    localparam logic [11:0] OFS_MCTRL = 12'h000;
    localparam logic [11:0] OFS_XCTRL = 12'h004;
    localparam logic [11:0] OFS_CSR = 12'h008;
    localparam logic [11:0] OFS_CMD = 12'h00c;
    localparam logic [11:0] OFS_RESULT = 12'h010;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h014;
    localparam logic [11:0] OFS_IRQ_CLEAR = 12'h018;
    localparam logic [11:0] OFS_IRQ_ENABLE = 12'h01c;
    localparam logic [11:0] OFS_LEGACY = 12'h020;
    localparam logic [11:0] OFS_DATA_BASE = 12'h040;
    localparam int NUM_DATA = 8;

    // machine and extension control fields
    localparam int MCTRL_EMU_BIT = 2;
    localparam int MCTRL_TSW_BIT = 3;
    localparam int MCTRL_NER_BIT = 5;
    localparam int XCTRL_OSH_BIT = 10;

    // control/status fields: six sticky flags low, six masks from bit 7
    localparam int NUM_FAULTS = 6;
    localparam int CSR_FLAG_LSB = 0;
    localparam int CSR_MASK_LSB = 7;
    localparam int F_INV = 0;
    localparam int F_ZDIV = 1;
    localparam int F_DEN = 2;
    localparam int F_OVF = 3;
    localparam int F_UNF = 4;
    localparam int F_INX = 5;

    // interrupt status bits
    localparam int NUM_IRQ = 4;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_SIMD = 1;
    localparam int IRQ_UDEF = 2;
    localparam int IRQ_NAVL = 3;

    // result register fields
    localparam int RES_IGN_BIT = 8;
    localparam int RES_FLAG_LSB = 16;

    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [5:0] RST_MASKS = 6'h00;

    // single precision constants
    localparam logic [31:0] QNAN_DEFAULT = 32'h7fc0_0000;
    localparam logic [7:0] EXP_ALL1 = 8'hff;
    localparam int EXP_BIAS = 127;
    localparam int MUL_REF = 46;
    localparam int DIV_REF = 26;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_FMUL = 4'h1,
        OP_FDIV = 4'h2,
        OP_PIADD = 4'h3,
        OP_MOVE = 4'h4,
        OP_FULL_SAVE = 4'h5,
        OP_FULL_RESTORE = 4'h6
    } sfx_op_t;

    typedef enum logic [1:0] {
        FLT_NONE = 2'h0,
        FLT_SIMD = 2'h1,
        FLT_UDEF = 2'h2,
        FLT_NAVL = 2'h3
    } sfx_fault_t;

    // command word as written to the command register
    typedef struct packed {
        logic [16:0] rsv;
        logic [2:0] srcb;
        logic srcb_pad;
        logic [2:0] srca;
        logic srca_pad;
        logic [2:0] dst;
        sfx_op_t op;
    } sfx_cmd_t;

    typedef struct packed {
        logic op_div;
        logic [31:0] a;
        logic [31:0] b;
    } sfx_fp_in_t;

    typedef struct packed {
        logic [NUM_FAULTS-1:0] flags;
        logic [31:0] result;
    } sfx_fp_out_t;

    typedef struct packed {
        logic emu;
        logic tsw;
        logic ner;
        logic osh;
        logic [NUM_FAULTS-1:0] flags;
        logic [NUM_FAULTS-1:0] masks;
        logic [NUM_DATA-1:0][31:0] data;
        logic [NUM_DATA-1:0][31:0] img_data;
        logic [NUM_FAULTS-1:0] img_flags;
        logic [NUM_FAULTS-1:0] img_masks;
        logic [31:0] img_legacy;
        logic [31:0] legacy;
        sfx_fault_t last_fault;
        logic [NUM_FAULTS-1:0] last_flags;
        logic [NUM_IRQ-1:0] irq_status;
        logic [NUM_IRQ-1:0] irq_enable;
        logic [31:0] prdata;
        logic pslverr;
        logic p_simd;
        logic p_udef;
        logic p_navl;
    } sfx_state_t;

endpackage

// [design/sfx_fp_arith.sv]
// single precision multiply/divide with fault classification and masked defaults
`timescale 1ns/100ps
module sfx_fp_arith (
    input wire sfx_pkg::sfx_fp_in_t fp_in,
    input wire logic [5:0] masks,
    output sfx_pkg::sfx_fp_out_t fp_out
);

    // position of the leading one, zero when none
    function automatic int lead_one(input logic [49:0] w);
        int k;
        k = 0;
        for (int i = 0; i < 50; i++) begin
            if (w[i]) begin
                k = i;
            end
        end
        return k;
    endfunction

    // operand class: {snan, nan, inf, zero, denormal}
    function automatic logic [4:0] classify(input logic [31:0] v);
        logic nan;
        nan = (v[30:23] == sfx_pkg::EXP_ALL1) && (v[22:0] != 23'h0);
        return {nan & ~v[22], nan, (v[30:23] == sfx_pkg::EXP_ALL1) && (v[22:0] == 23'h0),
            (v[30:0] == 31'h0), (v[30:23] == 8'h00) && (v[22:0] != 23'h0)};
    endfunction

    // classify, compute and substitute masked default results
    always_comb begin
        logic [4:0] ca;
        logic [4:0] cb;
        logic sr;
        logic [23:0] ma;
        logic [23:0] mb;
        logic [49:0] w;
        logic [49:0] sh;
        logic rem_nz;
        logic lost;
        int k;
        int ei;
        logic [5:0] fl;
        logic [31:0] res;
        ca = classify(fp_in.a);
        cb = classify(fp_in.b);
        sr = fp_in.a[31] ^ fp_in.b[31];
        ma = {fp_in.a[30:23] != 8'h00, fp_in.a[22:0]};
        mb = {fp_in.b[30:23] != 8'h00, fp_in.b[22:0]};
        w = '0;
        sh = '0;
        rem_nz = 1'b0;
        lost = 1'b0;
        k = 0;
        ei = 0;
        fl = '0;
        res = {sr, 31'h0};
        // a denormal operand is flagged on its own, outside ieee classes
        fl[sfx_pkg::F_DEN] = (ca[0] | cb[0]) & ~ca[3] & ~cb[3];
        if (ca[4] | cb[4] | (fp_in.op_div ? ((ca[1] & cb[1]) | (ca[2] & cb[2]))
                : ((ca[1] & cb[2]) | (ca[2] & cb[1])))) begin
            fl[sfx_pkg::F_INV] = 1'b1;
            res = sfx_pkg::QNAN_DEFAULT;
        end else if (ca[3]) begin
            res = fp_in.a | 32'h0040_0000;
        end else if (cb[3]) begin
            res = fp_in.b | 32'h0040_0000;
        end else if (fp_in.op_div && cb[1]) begin
            // finite nonzero over zero
            fl[sfx_pkg::F_ZDIV] = ~ca[2];
            res = {sr, sfx_pkg::EXP_ALL1, 23'h0};
        end else if (ca[2] | (~fp_in.op_div & cb[2])) begin
            res = {sr, sfx_pkg::EXP_ALL1, 23'h0};
        end else if (ca[1] | (~fp_in.op_div & cb[1]) | (fp_in.op_div & cb[2])) begin
            res = {sr, 31'h0};
        end else begin
            if (fp_in.op_div) begin
                w = {ma, 26'h0} / {26'h0, mb};
                rem_nz = ({ma, 26'h0} % {26'h0, mb}) != 50'h0;
            end else begin
                w = 50'(ma) * 50'(mb);
            end
            k = lead_one(w);
            ei = fp_in.op_div
                ? int'(fp_in.a[30:23] | 8'h00) + int'(ca[0]) - int'(fp_in.b[30:23])
                    - int'(cb[0]) + sfx_pkg::EXP_BIAS + k - sfx_pkg::DIV_REF
                : int'(fp_in.a[30:23]) + int'(ca[0]) + int'(fp_in.b[30:23])
                    + int'(cb[0]) - sfx_pkg::EXP_BIAS + k - sfx_pkg::MUL_REF;
            sh = w << (6'(49 - k));
            lost = (sh[25:0] != 26'h0) | rem_nz;
            fl[sfx_pkg::F_INX] = lost;
            res = {sr, ei[7:0], sh[48:26]};
            if (ei >= 255) begin
                fl[sfx_pkg::F_OVF] = 1'b1;
                fl[sfx_pkg::F_INX] = 1'b1;
                res = {sr, sfx_pkg::EXP_ALL1, 23'h0};
            end else if (ei <= 0) begin
                // tiny results flush to a signed zero
                fl[sfx_pkg::F_UNF] = 1'b1;
                fl[sfx_pkg::F_INX] = 1'b1;
                res = {sr, 31'h0};
            end
        end
        fp_out.flags = fl;
        fp_out.result = (|(fl & ~masks)) ? fp_in.a : res;
    end

endmodule

// [design/sfx_unused_guard.sv]
// interrupt level from the enabled sticky status bits
`timescale 1ns/100ps
module sfx_unused_guard (
    input wire logic [sfx_pkg::NUM_IRQ-1:0] irq_status,
    input wire logic [sfx_pkg::NUM_IRQ-1:0] irq_enable,
    output logic irq
);
    // level stays high while any enabled status bit is set
    assign irq = |(irq_status & irq_enable);
endmodule

// [testbench/sfx_properties.sv]
// port checker for the simd fp exception control block
`timescale 1ns/100ps
module sfx_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic simd_fp_fault,
    input wire logic invalid_opcode_fault,
    input wire logic device_unavailable_fault,
    input wire logic irq
);
    default clocking
        @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic cmd_d;
    logic irw_d;
    // last access phase wrote the command or an irq register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_d <= 1'b0;
            irw_d <= 1'b0;
        end else begin
            cmd_d <= psel && penable && pwrite && paddr == sfx_pkg::OFS_CMD;
            irw_d <= psel && penable && pwrite && paddr[11:3] == 9'h003;
        end
    end
    sequence s_bad;
        psel && penable && paddr == 12'h0fc;
    endsequence
    sequence s_fault;
        simd_fp_fault || invalid_opcode_fault || device_unavailable_fault;
    endsequence
    property p_ready;
        psel |-> pready;
    endproperty
    property p_bad;
        s_bad |-> pslverr;
    endproperty
    property p_good;
        psel && penable && paddr == sfx_pkg::OFS_CSR |-> !pslverr;
    endproperty
    property p_pulse;
        s_fault |=> !simd_fp_fault && !invalid_opcode_fault && !device_unavailable_fault;
    endproperty
    property p_xm;
        simd_fp_fault |-> cmd_d && !invalid_opcode_fault;
    endproperty
    property p_ud;
        invalid_opcode_fault |-> cmd_d && !device_unavailable_fault;
    endproperty
    property p_nm;
        device_unavailable_fault |-> cmd_d;
    endproperty
    property p_rise;
        $rose(irq) |-> cmd_d || irw_d || $past(cmd_d) || $past(irw_d);
    endproperty
    property p_fall;
        $fell(irq) |-> irw_d || $past(irw_d);
    endproperty
    a_ready: assert property (p_ready) else $error("pready low in a transfer");
    a_bad: assert property (p_bad) else $error("unmapped access without error");
    a_good: assert property (p_good) else $error("error on a mapped access");
    a_pulse: assert property (p_pulse) else $error("fault pulse too long");
    a_xm: assert property (p_xm) else $error("simd fault without command");
    a_ud: assert property (p_ud) else $error("bad invalid opcode pulse");
    a_nm: assert property (p_nm) else $error("bad unavailable pulse");
    a_rise: assert property (p_rise) else $error("irq rose without cause");
    a_fall: assert property (p_fall) else $error("irq fell without cause");
endmodule
bind sfx_simd_fp_exception_control sfx_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .simd_fp_fault(simd_fp_fault), .invalid_opcode_fault(invalid_opcode_fault),
    .device_unavailable_fault(device_unavailable_fault), .irq(irq)
);

// [testbench/sfx_simd_fp_exception_control_bench.sv]
// self-checking bench for the simd fp exception control block
`timescale 1ns/100ps
module sfx_simd_fp_exception_control_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic ign = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic xm;
    logic ud;
    logic nm;
    logic irq;
    logic [31:0] rd;
    logic rerr;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] ta [0:5] = '{32'h0, 32'h4000_0000, 32'h1, 32'h7f00_0000, 32'h0080_0000,
        32'h3f80_0000};
    logic [31:0] tb [0:5] = '{32'h0, 32'h0, 32'h3f80_0000, 32'h7f00_0000, 32'h0080_0000,
        32'h4040_0000};
    logic [31:0] tr [0:5] = '{32'h7fc0_0000, 32'h7f80_0000, 32'h0, 32'h7f80_0000, 32'h0,
        32'h3eaa_aaaa};
    sfx_simd_fp_exception_control dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ignore_numeric_error_input(ign),
        .simd_fp_fault(xm), .invalid_opcode_fault(ud),
        .device_unavailable_fault(nm), .irq(irq)
    );
    // clock and hang guard
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            failures = failures + 1;
            print_verdict();
        end
    end
    task automatic print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(string what, logic [11:0] a, logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask
    function automatic logic [11:0] dr(int i);
        return sfx_pkg::OFS_DATA_BASE + 12'(4 * i);
    endfunction
    task automatic ctl(logic emu, logic tsw, logic ner, logic osh);
        wr(sfx_pkg::OFS_MCTRL, {26'h0, ner, 1'b0, tsw, emu, 2'b00});
        wr(sfx_pkg::OFS_XCTRL, {21'h0, osh, 10'h0});
    endtask
    // issue a command and compare the pulses in the following cycle
    task automatic ex(logic [3:0] op, logic [2:0] d, logic [2:0] a, logic [2:0] b,
        logic [2:0] f);
        apb(1'b1, sfx_pkg::OFS_CMD, {17'h0, b, 1'b0, a, 1'b0, d, op});
        #1;
        check("fault pulses", {29'h0, f}, {29'h0, xm, ud, nm});
    endtask
    task automatic t_reset;
        rdchk("csr", sfx_pkg::OFS_CSR, 32'h0);
        rdchk("irq status", sfx_pkg::OFS_IRQ_STATUS, 32'h0);
        apb(1'b0, 12'h0fc, 32'h0);
        check("unmapped error", 32'h1, {31'h0, rerr});
    endtask
    // every class masked: sticky flag, no pulse, default result for all but denormal
    task automatic t_masked;
        for (int k = 0; k < 6; k++) begin
            wr(sfx_pkg::OFS_CSR, 32'h0000_1f80);
            wr(dr(0), ta[k]);
            wr(dr(1), tb[k]);
            ex(k inside {0, 1, 5} ? 4'h2 : 4'h1, 3'd2, 3'd0, 3'd1, 3'b000);
            apb(1'b0, sfx_pkg::OFS_CSR, 32'h0);
            check("class flag", 32'h1, {31'h0, rd[k]});
            if (k != sfx_pkg::F_DEN) begin
                rdchk("default result", dr(2), tr[k]);
            end
        end
    endtask
    // unmasked fault with error flag clear, then set with handler flag clear, ignore pin high
    task automatic t_unmasked;
        ign <= 1'b1;
        ctl(1'b0, 1'b0, 1'b0, 1'b1);
        wr(sfx_pkg::OFS_CSR, 32'h0);
        wr(dr(0), 32'h4000_0000);
        wr(dr(1), 32'h0);
        wr(dr(2), 32'h1234_5678);
        ex(4'h2, 3'd2, 3'd0, 3'd1, 3'b100);
        rdchk("dest kept", dr(2), 32'h1234_5678);
        apb(1'b0, sfx_pkg::OFS_RESULT, 32'h0);
        check("result word", 32'h0002_0101, rd & 32'h0002_0103);
        ctl(1'b0, 1'b0, 1'b1, 1'b0);
        ex(4'h2, 3'd2, 3'd0, 3'd1, 3'b010);
        rdchk("dest kept", dr(2), 32'h1234_5678);
        ign <= 1'b0;
    endtask
    task automatic t_pint;
        ctl(1'b0, 1'b0, 1'b1, 1'b1);
        wr(dr(0), 32'h7fc0_0000);
        wr(dr(1), 32'h7f80_0000);
        ex(4'h3, 3'd2, 3'd0, 3'd1, 3'b000);
        rdchk("lane sum", dr(2), 32'hfe40_0000);
    endtask
    // emulate flag wins over task switched; both block the write
    task automatic t_gate;
        wr(dr(2), 32'h0);
        ctl(1'b1, 1'b1, 1'b1, 1'b1);
        ex(4'h4, 3'd2, 3'd0, 3'd1, 3'b010);
        ctl(1'b0, 1'b1, 1'b1, 1'b1);
        ex(4'h1, 3'd2, 3'd0, 3'd1, 3'b001);
        ex(4'h5, 3'd0, 3'd0, 3'd0, 3'b001);
        rdchk("dest kept", dr(2), 32'h0);
        ctl(1'b0, 1'b0, 1'b1, 1'b1);
    endtask
    task automatic t_state;
        for (int i = 0; i < 8; i++) begin
            wr(dr(i), {4{8'(i)}});
        end
        wr(sfx_pkg::OFS_CSR, 32'h0000_1f85);
        wr(sfx_pkg::OFS_LEGACY, 32'ha5a5_0f0f);
        ex(4'h5, 3'd0, 3'd0, 3'd0, 3'b000);
        for (int i = 0; i < 8; i++) begin
            wr(dr(i), ~{4{8'(i)}});
        end
        wr(sfx_pkg::OFS_CSR, 32'h0);
        wr(sfx_pkg::OFS_LEGACY, 32'h0);
        rdchk("data piece", dr(3), 32'hfcfc_fcfc);
        rdchk("csr piece", sfx_pkg::OFS_CSR, 32'h0);
        ex(4'h6, 3'd0, 3'd0, 3'd0, 3'b000);
        for (int i = 0; i < 8; i++) begin
            rdchk("data image", dr(i), {4{8'(i)}});
        end
        rdchk("csr image", sfx_pkg::OFS_CSR, 32'h0000_1f85);
        rdchk("legacy image", sfx_pkg::OFS_LEGACY, 32'ha5a5_0f0f);
    endtask
    task automatic t_irq;
        wr(sfx_pkg::OFS_IRQ_ENABLE, 32'h0);
        wr(sfx_pkg::OFS_IRQ_CLEAR, 32'hf);
        rdchk("irq status", sfx_pkg::OFS_IRQ_STATUS, 32'h0);
        ex(4'h4, 3'd1, 3'd0, 3'd0, 3'b000);
        rdchk("irq status", sfx_pkg::OFS_IRQ_STATUS, 32'h1);
        check("irq", 32'h0, {31'h0, irq});
        wr(sfx_pkg::OFS_IRQ_ENABLE, 32'h1);
        rdchk("irq enable", sfx_pkg::OFS_IRQ_ENABLE, 32'h1);
        check("irq", 32'h1, {31'h0, irq});
        wr(sfx_pkg::OFS_IRQ_CLEAR, 32'h1);
        rdchk("irq status", sfx_pkg::OFS_IRQ_STATUS, 32'h0);
        check("irq", 32'h0, {31'h0, irq});
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_masked();
        t_unmasked();
        t_pint();
        t_gate();
        t_state();
        t_irq();
        print_verdict();
    end
endmodule
